// >>> include/usi_pkg.sv
// Shared register map, field positions and carrier types of the serial shift block.
`default_nettype none
package usi_pkg;
  // Word offsets on the bus (byte addresses, one aligned word each).
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_PINPOS = 4'hc;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h0;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
  // Control register fields.
  localparam int CTL_TOGGLE = 0;
  localparam int CTL_STROBE = 1;
  localparam int CTL_CS_LO = 2;
  localparam int CTL_CS_HI = 3;
  localparam int CTL_WM_LO = 4;
  localparam int CTL_WM_HI = 5;
  // Status register fields.
  localparam int STAT_OVF = 7;
  localparam int STAT_CNT_LSB = 0;
  // Interrupt event bits.
  localparam int EV_OVF = 0;
  localparam int EV_BYTE = 1;
  localparam int NUM_EV = 2;
  // Reset values.
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic PINPOS_RST = 1'b0;

  typedef struct packed {
    logic [1:0] wire_mode;
    logic [1:0] clock_source_select;
    logic soft_strobe_bit;
  } ctl_t;

  typedef struct packed {
    logic do_val;
    logic clk_val;
    logic clk_oe;
    logic do_oe;
  } pin_out_t;
endpackage
`default_nettype wire

// >>> rtl/usi_sync.sv
// Two-flop synchroniser with edge detection after the second stage.
`default_nettype none
module usi_sync (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Async in, synchronous out
  input wire logic d_i,
  output logic q_o,
  output logic rise_o,
  output logic fall_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign q_o = s2_r;
  assign rise_o = ce_i & s2_r & ~s3_r;
  assign fall_o = ce_i & ~s2_r & s3_r;
endmodule
`default_nettype wire

// >>> rtl/usi_pin_mux.sv
// Routes the interface pin functions to one of two port pin groups.
`default_nettype none
module usi_pin_mux (
  // Selection
  input wire logic pos_i,
  // Functional side
  input wire usi_pkg::pin_out_t fn_i,
  // Group B pins, bit 0 data in, bit 1 data out, bit 2 clock
  output logic [2:0] grp_b_o,
  output logic [2:0] grp_b_oe_o,
  // Group A pins
  output logic [2:0] grp_a_o,
  output logic [2:0] grp_a_oe_o
);
  wire [2:0] val = {fn_i.clk_val, fn_i.do_val, 1'b0};
  wire [2:0] oe = {fn_i.clk_oe, fn_i.do_oe, 1'b0};
  assign grp_b_o = pos_i ? 3'h0 : val;
  assign grp_b_oe_o = pos_i ? 3'h0 : oe;
  assign grp_a_o = pos_i ? val : 3'h0;
  assign grp_a_oe_o = pos_i ? oe : 3'h0;
endmodule
`default_nettype wire

// >>> rtl/usi_shift_clocking.sv
// Serial shift register, edge counter, clock routing and register slave.
`default_nettype none
module usi_shift_clocking #(
  parameter int DATA_W = 8,
  parameter int CNT_W = 4
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins, group B and group A, bit 0 data in, bit 1 data out, bit 2 clock
  input wire logic [2:0] grp_b_i,
  input wire logic [2:0] grp_a_i,
  output logic [2:0] grp_b_o,
  output logic [2:0] grp_b_oe_o,
  output logic [2:0] grp_a_o,
  output logic [2:0] grp_a_oe_o,
  // Pin direction settings for data out and clock
  input wire logic do_dir_i,
  input wire logic clock_pin_direction_bit_i,
  // Interrupt
  output logic irq_o
);
  logic [DATA_W-1:0] shift_data_register_r;
  logic [CNT_W-1:0] cnt_r;
  logic counter_overflow_flag_r;
  usi_pkg::ctl_t ctl_r;
  logic pin_position_bit_r;
  logic clk_port_r;
  logic [usi_pkg::NUM_EV-1:0] irq_stat_r;
  logic [usi_pkg::NUM_EV-1:0] irq_mask_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic din_prev_r;
  logic irq_r;
  logic [2:0] gb_r;
  logic [2:0] gbe_r;
  logic [2:0] ga_r;
  logic [2:0] gae_r;

  // Bus decode; adr_i bit 4 picks the interrupt bank.
  wire req = cyc_i & stb_i & ~ack_r & ce_i;
  wire wr = req & we_i & sel_i[0];
  wire rd = req & ~we_i;
  wire bank_irq = adr_i[4];
  wire [3:0] off = {adr_i[3:2], 2'b00};
  wire wr_ctl = wr & ~bank_irq & (off == usi_pkg::OFF_CONTROL);
  wire wr_stat = wr & ~bank_irq & (off == usi_pkg::OFF_STATUS);
  wire wr_data = wr & ~bank_irq & (off == usi_pkg::OFF_DATA);
  wire wr_pos = wr & ~bank_irq & (off == usi_pkg::OFF_PINPOS);
  wire wr_mask = wr & bank_irq & (off == usi_pkg::OFF_IRQ_MASK);
  wire rd_istat = rd & bank_irq & (off == usi_pkg::OFF_IRQ_STAT);

  // Pin inputs pass two flops before use; the selected group feeds the logic.
  logic din_b;
  logic din_a;
  logic sck_b;
  logic sck_a;
  logic sck_b_rise;
  logic sck_b_fall;
  logic sck_a_rise;
  logic sck_a_fall;
  usi_sync u_din_b (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(grp_b_i[0]),
    .q_o(din_b), .rise_o(), .fall_o());
  usi_sync u_din_a (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(grp_a_i[0]),
    .q_o(din_a), .rise_o(), .fall_o());
  usi_sync u_sck_b (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(grp_b_i[2]),
    .q_o(sck_b), .rise_o(sck_b_rise), .fall_o(sck_b_fall));
  usi_sync u_sck_a (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .d_i(grp_a_i[2]),
    .q_o(sck_a), .rise_o(sck_a_rise), .fall_o(sck_a_fall));

  // Edges are qualified by the pin position.
  wire din = pin_position_bit_r ? din_a : din_b;
  wire ext_rise = pin_position_bit_r ? sck_a_rise : sck_b_rise;
  wire ext_fall = pin_position_bit_r ? sck_a_fall : sck_b_fall;

  // Control write decode; strobe and toggle are taken from the written data.
  wire wr_strobe = wr_ctl & dat_i[usi_pkg::CTL_STROBE];
  wire wr_toggle = wr_ctl & dat_i[usi_pkg::CTL_TOGGLE];
  // The clock source chosen by this very write governs it, so one write both
  // configures and strobes, which the fastest master sequence relies on.
  wire [1:0] cs_new = {dat_i[usi_pkg::CTL_CS_HI], dat_i[usi_pkg::CTL_CS_LO]};
  wire [1:0] cs_eff = wr_ctl ? cs_new : ctl_r.clock_source_select;
  wire sel_eff = wr_ctl ? dat_i[usi_pkg::CTL_STROBE] : ctl_r.soft_strobe_bit;
  wire ext_src = cs_eff[1];

  // Shift and count events per source.
  wire soft_shift = wr_strobe & (cs_eff == 2'b00);
  wire ext_shift = ext_src & (cs_eff[0] ? ext_fall : ext_rise);
  wire shift_ev = soft_shift | ext_shift;
  wire tog_count = ext_src & sel_eff & wr_toggle;
  wire both_count = ext_src & ~sel_eff & cs_eff[0] & (ext_rise | ext_fall);
  wire count_ev = soft_shift | tog_count | both_count;
  wire [CNT_W-1:0] cnt_nxt = cnt_r + CNT_W'(1);
  wire wrap = count_ev & (cnt_r == {CNT_W{1'b1}});
  wire byte_done = wrap;

  // Status: overflow flag, counter.
  wire ovf_clear = wr_stat & dat_i[usi_pkg::STAT_OVF];
  wire [usi_pkg::NUM_EV-1:0] ev_vec = {byte_done & shift_ev, wrap};
  wire [usi_pkg::NUM_EV-1:0] irq_stat_nxt = (rd_istat ? '0 : irq_stat_r) | ev_vec;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_prev_r <= 1'b0;
    end else if (ce_i) begin
      din_prev_r <= din;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_data_register_r <= usi_pkg::DATA_RST;
    end else if (ce_i) begin
      if (shift_ev) begin
        shift_data_register_r <= {shift_data_register_r[DATA_W-2:0], din_prev_r};
      end else if (wr_data) begin
        shift_data_register_r <= dat_i[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= usi_pkg::COUNT_RST;
    end else if (ce_i) begin
      if (count_ev) begin
        cnt_r <= cnt_nxt;
      end else if (wr_stat) begin
        cnt_r <= dat_i[usi_pkg::STAT_CNT_LSB +: CNT_W];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_overflow_flag_r <= 1'b0;
    end else if (ce_i) begin
      counter_overflow_flag_r <= wrap | (counter_overflow_flag_r & ~ovf_clear);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= '0;
      pin_position_bit_r <= usi_pkg::PINPOS_RST;
      clk_port_r <= 1'b0;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
    end else if (ce_i) begin
      if (wr_ctl) begin
        ctl_r.wire_mode <= {dat_i[usi_pkg::CTL_WM_HI], dat_i[usi_pkg::CTL_WM_LO]};
        ctl_r.clock_source_select <= cs_new;
        ctl_r.soft_strobe_bit <= cs_new[1] & dat_i[usi_pkg::CTL_STROBE];
      end
      if (wr_pos) begin
        pin_position_bit_r <= dat_i[0];
      end
      if (wr_toggle) begin
        clk_port_r <= ~clk_port_r;
      end
      if (wr_mask) begin
        irq_mask_r <= dat_i[usi_pkg::NUM_EV-1:0];
      end
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Read mux; action bits never read back.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (bank_irq) begin
      rd_val[usi_pkg::NUM_EV-1:0] = (off == usi_pkg::OFF_IRQ_MASK) ? irq_mask_r :
        (off == usi_pkg::OFF_IRQ_STAT) ? irq_stat_r : '0;
    end else begin
      unique case (off)
        usi_pkg::OFF_CONTROL: begin
          rd_val[usi_pkg::CTL_WM_HI] = ctl_r.wire_mode[1];
          rd_val[usi_pkg::CTL_WM_LO] = ctl_r.wire_mode[0];
          rd_val[usi_pkg::CTL_CS_HI] = ctl_r.clock_source_select[1];
          rd_val[usi_pkg::CTL_CS_LO] = ctl_r.clock_source_select[0];
        end
        usi_pkg::OFF_STATUS: begin
          rd_val[usi_pkg::STAT_OVF] = counter_overflow_flag_r;
          rd_val[usi_pkg::STAT_CNT_LSB +: CNT_W] = cnt_r;
        end
        usi_pkg::OFF_DATA: rd_val[DATA_W-1:0] = shift_data_register_r;
        usi_pkg::OFF_PINPOS: rd_val[0] = pin_position_bit_r;
        default: rd_val = 32'h0;
      endcase
    end
  end

  // Data out taken from the register state after this edge's shift.
  wire [DATA_W-1:0] sdr_nxt = shift_ev ? {shift_data_register_r[DATA_W-2:0], din_prev_r} :
    wr_data ? dat_i[DATA_W-1:0] : shift_data_register_r;
  usi_pkg::pin_out_t pins;
  assign pins.do_val = sdr_nxt[DATA_W-1];
  assign pins.clk_val = wr_toggle ? ~clk_port_r : clk_port_r;
  assign pins.clk_oe = clock_pin_direction_bit_i;
  assign pins.do_oe = do_dir_i;
  wire pos_nxt = wr_pos ? dat_i[0] : pin_position_bit_r;
  logic [2:0] gb;
  logic [2:0] gbe;
  logic [2:0] ga;
  logic [2:0] gae;
  usi_pin_mux u_mux (.pos_i(pos_nxt), .fn_i(pins), .grp_b_o(gb), .grp_b_oe_o(gbe),
    .grp_a_o(ga), .grp_a_oe_o(gae));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      irq_r <= 1'b0;
      gb_r <= 3'h0;
      gbe_r <= 3'h0;
      ga_r <= 3'h0;
      gae_r <= 3'h0;
    end else if (ce_i) begin
      ack_r <= req;
      dat_r <= rd ? rd_val : 32'h0;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      gb_r <= gb;
      gbe_r <= gbe;
      ga_r <= ga;
      gae_r <= gae;
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign irq_o = irq_r;
  assign grp_b_o = gb_r;
  assign grp_b_oe_o = gbe_r;
  assign grp_a_o = ga_r;
  assign grp_a_oe_o = gae_r;

  // Checks.
  soft_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    soft_shift |=> cnt_r == $past(cnt_nxt)) else $error("strobe did not step counter");
  do_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && shift_ev |=> grp_b_o[1] == $past(sdr_nxt[DATA_W-1]) || pin_position_bit_r)
    else $error("data out lagged shift");
  shift_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    shift_ev |=> shift_data_register_r[0] == $past(din_prev_r)) else $error("bad shift in");
  action_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(rd && !bank_irq && off == usi_pkg::OFF_CONTROL) |-> dat_o[1:0] == 2'b00)
    else $error("action bit read one");
  toggle_inv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_toggle |=> clk_port_r != $past(clk_port_r)) else $error("toggle missed");
  tog_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tog_count && !soft_shift |=> cnt_r == $past(cnt_nxt)) else $error("toggle count missed");
  reserved_pos_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && $past(rd && !bank_irq && off == usi_pkg::OFF_PINPOS) |-> dat_o[31:1] == '0)
    else $error("reserved bits set");
  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap |=> counter_overflow_flag_r && cnt_r == '0) else $error("overflow not flagged");
  group_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pin_position_bit_r && !wr_pos |=> grp_b_oe_o == 3'h0) else $error("group B driven");
endmodule
`default_nettype wire

// >>> bench/serial_peer_model.sv
// Behavioural serial peer that acts as a slave or as the clock master on the link.
`default_nettype none
module serial_peer_model (
  // Link pads
  input wire logic sck_pad_i,
  output logic sck_drv_o,
  output logic sck_en_o,
  output logic sdi_drv_o,
  output logic sdi_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  int cnt = 8;
  initial begin
    {sck_drv_o, sck_en_o, sdi_drv_o, sdi_en_o} = 4'h0;
  end
  // As a slave the MSB is shown at once, so it is settled before the first rising edge.
  task automatic slave_load(input logic [7:0] b);
    sh = b;
    cnt = 0;
    sdi_drv_o = b[7];
    sdi_en_o = 1'b1;
  endtask
  // The next bit follows each falling edge; after the eighth the line is released.
  always @(negedge sck_pad_i) begin
    if (cnt < 8) begin
      cnt = cnt + 1;
      sdi_drv_o = (cnt < 8) ? sh[7 - cnt] : ~sdi_drv_o;
      sdi_en_o = (cnt < 8);
    end
  end
  // As master it gives eight pulses at an 800 ns period, and the clock rests low between frames.
  task automatic master_send(input logic [7:0] b);
    #37;
    sck_en_o = 1'b1;
    sdi_en_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sdi_drv_o = b[i];
      #200 sck_drv_o = 1'b1;
      #400 sck_drv_o = 1'b0;
      #200;
    end
    sck_en_o = 1'b0;
    sdi_en_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/universal_serial_shift_clocking_tb_top.sv
// Self-checking bench for the serial shift clocking block and its register slave.
`default_nettype none
module universal_serial_shift_clocking_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack_o, irq_o, sck_drv, sck_en, sdi_drv, sdi_en;
  logic do_dir = 1'b1;
  logic ck_dir = 1'b0;
  logic [2:0] grp_b_o, grp_b_oe_o, grp_a_o, grp_a_oe_o, pad_b, pad_a;
  int miscompares = 0;
  int tests_run = 0;
  // Undriven pads: clock lines pulled low, data lines pulled high.
  assign pad_b[2] = grp_b_oe_o[2] ? grp_b_o[2] : (sck_en ? sck_drv : 1'b0);
  assign pad_b[1] = grp_b_oe_o[1] ? grp_b_o[1] : 1'b1;
  assign pad_b[0] = grp_b_oe_o[0] ? grp_b_o[0] : (sdi_en ? sdi_drv : 1'b1);
  assign pad_a[2] = grp_a_oe_o[2] ? grp_a_o[2] : 1'b0;
  assign pad_a[1] = grp_a_oe_o[1] ? grp_a_o[1] : 1'b1;
  assign pad_a[0] = grp_a_oe_o[0] ? grp_a_o[0] : 1'b1;

  usi_shift_clocking usi_shift_clocking_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .grp_b_i(pad_b), .grp_a_i(pad_a), .grp_b_o(grp_b_o),
    .grp_b_oe_o(grp_b_oe_o), .grp_a_o(grp_a_o), .grp_a_oe_o(grp_a_oe_o),
    .do_dir_i(do_dir), .clock_pin_direction_bit_i(ck_dir), .irq_o(irq_o));
  serial_peer_model serial_peer_model_inst (.sck_pad_i(pad_b[2]), .sck_drv_o(sck_drv),
    .sck_en_o(sck_en), .sdi_drv_o(sdi_drv), .sdi_en_o(sdi_en));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(5'h18, 32'hff);
    for (int a = 0; a < 28; a += 4) rchk(5'(a), 32'h0);
    $display("test reset done");
    wr(5'h08, 32'h81);
    tick(2);
    chk(32'(grp_b_o[1]), 32'h1);
    wr(5'h00, 32'h02);
    tick(1);
    chk(32'(grp_b_o[1]), 32'h0);
    rchk(5'h08, 32'h03);
    rchk(5'h04, 32'h01);
    rchk(5'h00, 32'h00);
    $display("test strobe done");
    wr(5'h00, 32'h01);
    tick(1);
    chk(32'({grp_b_oe_o[2], grp_b_o[2]}), 32'h1);
    @(posedge clk_i);
    ck_dir <= 1'b1;
    tick(2);
    chk(32'({grp_b_oe_o[2], grp_b_o[2]}), 32'h3);
    wr(5'h00, 32'h01);
    tick(1);
    chk(32'(grp_b_o[2]), 32'h0);
    $display("test toggle done");
    wr(5'h04, 32'h80);
    wr(5'h08, 32'ha5);
    for (int i = 0; i < 8; i++) begin
      wr(5'h00, 32'h11);
      wr(5'h00, 32'h13);
    end
    tick(2);
    rchk(5'h08, 32'hff);
    rchk(5'h04, 32'h08);
    chk(32'(grp_b_o[2]), 32'h0);
    $display("test fast master done");
    wr(5'h04, 32'h80);
    serial_peer_model_inst.slave_load(8'h5a);
    for (int i = 0; i < 16; i++) wr(5'h00, 32'h1b);
    tick(8);
    rchk(5'h08, 32'h5a);
    rchk(5'h04, 32'h80);
    rchk(5'h00, 32'h18);
    chk(32'(irq_o), 32'h0);
    wr(5'h10, 32'h01);
    tick(2);
    chk(32'(irq_o), 32'h1);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd & 32'h1, 32'h1);
    tick(2);
    chk(32'(irq_o), 32'h0);
    rchk(5'h04, 32'h80);
    wr(5'h04, 32'h80);
    rchk(5'h04, 32'h00);
    $display("test toggle counted master done");
    @(posedge clk_i);
    ck_dir <= 1'b0;
    wr(5'h04, 32'h80);
    wr(5'h00, 32'h1c);
    serial_peer_model_inst.master_send(8'hc3);
    tick(8);
    rchk(5'h08, 32'hc3);
    rchk(5'h04, 32'h80);
    wr(5'h04, 32'h80);
    wr(5'h00, 32'h1e);
    serial_peer_model_inst.master_send(8'h3c);
    tick(8);
    rchk(5'h08, 32'h3c);
    rchk(5'h04, 32'h00);
    wr(5'h00, 32'h18);
    serial_peer_model_inst.master_send(8'h96);
    tick(8);
    rchk(5'h08, 32'h96);
    rchk(5'h04, 32'h00);
    rchk(5'h00, 32'h18);
    wr(5'h00, 32'h1f);
    tick(2);
    rchk(5'h04, 32'h01);
    $display("test external clock done");
    @(posedge clk_i);
    ck_dir <= 1'b1;
    wr(5'h0c, 32'hff);
    rchk(5'h0c, 32'h01);
    wr(5'h00, 32'h01);
    tick(2);
    chk(32'({grp_a_oe_o[2], grp_a_o[2], grp_b_oe_o}), 32'h10);
    wr(5'h00, 32'h01);
    tick(2);
    chk(32'(grp_a_o[2]), 32'h1);
    $display("test pin position done");
    wrap_up();
  end
endmodule
`default_nettype wire
